// [src/adc_cfg_pkg.sv]
// constants, types and register map of the converter setup and limit comparator
package adc_cfg_pkg;
    //----------------------------------------
    // register pointer
    //----------------------------------------
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_SETUP = 2'h1;
    localparam logic [1:0] PTR_LOWER = 2'h2;
    localparam logic [1:0] PTR_UPPER = 2'h3;
    //----------------------------------------
    // setup register fields
    //----------------------------------------
    localparam int START_BIT = 15;
    localparam int MUX_LSB = 12;
    localparam int GAIN_LSB = 9;
    localparam int MODE_BIT = 8;
    localparam int RATE_LSB = 5;
    localparam int CMODE_BIT = 4;
    localparam int POL_BIT = 3;
    localparam int LAT_BIT = 2;
    localparam int QUE_LSB = 0;
    localparam logic [2:0] MUX_RST = 3'h0;
    localparam logic [2:0] GAIN_RST = 3'h2;
    localparam logic MODE_RST = 1'h1;
    localparam logic [2:0] RATE_RST = 3'h4;
    localparam logic CMODE_RST = 1'h0;
    localparam logic POL_RST = 1'h0;
    localparam logic LAT_RST = 1'h0;
    localparam logic [1:0] QUE_RST = 2'h3;
    localparam logic [14:0] SETUP_RST = {MUX_RST, GAIN_RST, MODE_RST, RATE_RST,
                                         CMODE_RST, POL_RST, LAT_RST, QUE_RST};
    localparam logic MODE_CONT = 1'h0;
    localparam logic CMODE_WINDOW = 1'h1;
    localparam logic [1:0] QUE_OFF = 2'h3;
    localparam logic [2:0] QUE_NEED [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    localparam logic [2:0] FAULT_MAX = 3'h4;
    localparam logic [15:0] LOWER_RST = 16'h8000;
    localparam logic [15:0] UPPER_RST = 16'h7fff;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    //----------------------------------------
    // full-scale span in millivolts per gain code
    //----------------------------------------
    localparam logic [12:0] SPAN_MV [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400,
                                           13'h0200, 13'h0100, 13'h0100, 13'h0100};
    localparam logic [12:0] SPAN_FIXED = 13'h0800;
    //----------------------------------------
    // timing
    //----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int RATE_NUM = 8;
    localparam int unsigned RATE_SPS [RATE_NUM] = '{8, 16, 32, 64, 128, 250, 475, 860};
    function automatic int unsigned conv_cycles(input int unsigned sps);
        return 1_000_000_000 / (CLK_PERIOD_NS * sps);
    endfunction
    localparam int unsigned RATE_CYC_DEF [RATE_NUM] = '{
        conv_cycles(RATE_SPS[0]), conv_cycles(RATE_SPS[1]), conv_cycles(RATE_SPS[2]),
        conv_cycles(RATE_SPS[3]), conv_cycles(RATE_SPS[4]), conv_cycles(RATE_SPS[5]),
        conv_cycles(RATE_SPS[6]), conv_cycles(RATE_SPS[7])};
    localparam int CONV_CNT_W = 23;
    localparam int unsigned RDY_PULSE_NS = 8000;
    localparam int unsigned RDY_PULSE_CYC = (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RDY_CNT_W = 9;
    //----------------------------------------
    // link words and states
    //----------------------------------------
    typedef enum logic [1:0] {
        REQ_NONE = 2'b00,
        REQ_WRITE = 2'b01,
        REQ_READ = 2'b10,
        REQ_ARA = 2'b11
    } req_kind_e;
    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_RUN = 1'b1
    } conv_state_e;
    localparam int REQ_W = 20;
    localparam int ANS_W = 16;
    localparam int ARA_HIT_BIT = 15;
    localparam int ADDR_LSB = 1;
endpackage

// [src/word_cross.sv]
// toggle handshake that carries a word and its strobe into another clock domain
`timescale 1ns/10ps
module word_cross #(
    parameter int W = 16 // word width
) (
    input wire logic i_src_clk, // source clock
    input wire logic i_src_rst_n, // source synchronous reset, active low
    input wire logic i_src_valid, // one-cycle strobe with the word
    input wire logic [W-1:0] i_src_data, // word taken with the strobe
    input wire logic i_dst_clk, // destination clock
    input wire logic i_dst_rst_n, // destination synchronous reset, active low
    output logic o_dst_valid, // one-cycle strobe in the destination domain
    output logic [W-1:0] o_dst_data // word, held until the next strobe
);
    //----------------------------------------
    // source side
    //----------------------------------------
    logic tog_r, tog_nxt;
    logic [W-1:0] hold_r, hold_nxt;
    logic sy1_r, sy2_r, sy3_r;
    logic valid_nxt;
    logic [W-1:0] data_nxt;

    // the word stays put after the toggle so the far side can take it safely
    always_comb begin
        tog_nxt = tog_r;
        hold_nxt = hold_r;
        if (i_src_valid) begin
            tog_nxt = ~tog_r;
            hold_nxt = i_src_data;
        end
    end

    always_ff @(posedge i_src_clk) begin
        if (!i_src_rst_n) begin
            tog_r <= 1'b0;
            hold_r <= '0;
        end else begin
            tog_r <= tog_nxt;
            hold_r <= hold_nxt;
        end
    end

    //----------------------------------------
    // destination side
    //----------------------------------------
    // only sy2 and sy3 are compared; sy1 feeds sy2 alone
    always_comb begin
        valid_nxt = sy2_r ^ sy3_r;
        data_nxt = valid_nxt ? hold_r : o_dst_data;
    end

    always_ff @(posedge i_dst_clk) begin
        if (!i_dst_rst_n) begin
            sy1_r <= 1'b0;
            sy2_r <= 1'b0;
            sy3_r <= 1'b0;
            o_dst_valid <= 1'b0;
            o_dst_data <= '0;
        end else begin
            sy1_r <= tog_r;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            o_dst_valid <= valid_nxt;
            o_dst_data <= data_nxt;
        end
    end
endmodule // word_cross

// [src/adc_config_threshold_comparator.sv]
// converter setup registers, conversion timer and digital limit comparator
`timescale 1ns/10ps
module adc_config_threshold_comparator
    import adc_cfg_pkg::*;
#(
    parameter bit HAS_COMPARATOR = 1'b1, // 0 builds the fixed-span variant
    parameter int unsigned RATE_CYC [RATE_NUM] = RATE_CYC_DEF // cycles per conversion
) (
    input wire logic i_mclk, // core clock, 40 mhz
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic [15:0] i_sample, // filter result, taken at conversion end
    input wire logic [6:0] i_dev_addr, // own serial address
    input wire logic i_lclk, // serial engine clock
    input wire logic i_lwr, // write pulse from the serial engine
    input wire logic i_lrd, // read pulse from the serial engine
    input wire logic i_lara, // alert-response pulse from the serial engine
    input wire logic [1:0] i_lptr, // register pointer
    input wire logic [15:0] i_lwdata, // write word
    output logic [15:0] o_lrdata, // read answer word, link domain
    output logic o_lrvalid, // read answer pulse, link domain
    output logic o_alert_out, // alert/ready pin level
    output logic o_alert_oe, // alert/ready pin driven
    output logic o_conv_busy, // conversion running, powers the front end
    output logic [2:0] o_gain_range, // gain range to the front end
    output logic [2:0] o_rate, // rate to the filter
    output logic [12:0] o_span_mv // full-scale span in millivolts
);
    //----------------------------------------
    // link side and crossings
    //----------------------------------------
    logic lrst_s1_r, lrst_s2_r;
    req_kind_e lreq_kind, req_kind;
    logic req_v;
    logic [REQ_W-1:0] req_word;
    logic [1:0] req_ptr;
    logic [15:0] req_data;
    logic ans_v_r, ans_v_nxt;
    logic [ANS_W-1:0] ans_r, ans_nxt;

    // reset release carried into the link domain
    always_ff @(posedge i_lclk) begin
        lrst_s1_r <= i_rst_n;
        lrst_s2_r <= lrst_s1_r;
    end

    // one request per strobe, write first
    always_comb begin
        lreq_kind = REQ_NONE;
        if (i_lwr) begin
            lreq_kind = REQ_WRITE;
        end else if (i_lrd) begin
            lreq_kind = REQ_READ;
        end else if (i_lara) begin
            lreq_kind = REQ_ARA;
        end
    end

    word_cross #(.W(REQ_W)) u_req (
        .i_src_clk(i_lclk),
        .i_src_rst_n(lrst_s2_r),
        .i_src_valid(lreq_kind != REQ_NONE),
        .i_src_data({lreq_kind, i_lptr, i_lwdata}),
        .i_dst_clk(i_mclk),
        .i_dst_rst_n(i_rst_n),
        .o_dst_valid(req_v),
        .o_dst_data(req_word)
    );

    word_cross #(.W(ANS_W)) u_ans (
        .i_src_clk(i_mclk),
        .i_src_rst_n(i_rst_n),
        .i_src_valid(ans_v_r),
        .i_src_data(ans_r),
        .i_dst_clk(i_lclk),
        .i_dst_rst_n(lrst_s2_r),
        .o_dst_valid(o_lrvalid),
        .o_dst_data(o_lrdata)
    );

    // request fields
    always_comb begin
        req_kind = req_v ? req_kind_e'(req_word[19:18]) : REQ_NONE;
        req_ptr = req_word[17:16];
        req_data = req_word[15:0];
    end

    //----------------------------------------
    // register bank
    //----------------------------------------
    logic [14:0] setup_r, setup_nxt;
    logic [15:0] lower_r, lower_nxt, upper_r, upper_nxt, result_r, result_nxt;
    logic wr_setup;
    logic [2:0] gain, rate_sel;
    logic [1:0] que;
    logic mode, cmode, pol, lat;
    conv_state_e state_r, state_nxt;
    logic [CONV_CNT_W-1:0] cnt_r, cnt_nxt;
    logic done, start_single;
    logic alert_act_r;

    assign gain = setup_r[GAIN_LSB +: 3];
    assign mode = setup_r[MODE_BIT];
    assign rate_sel = setup_r[RATE_LSB +: 3];
    assign cmode = setup_r[CMODE_BIT];
    assign pol = setup_r[POL_BIT];
    assign lat = setup_r[LAT_BIT];
    assign que = setup_r[QUE_LSB +: 2];
    assign wr_setup = req_kind == REQ_WRITE && req_ptr == PTR_SETUP;

    // writes, result capture and read answers
    always_comb begin
        setup_nxt = wr_setup ? req_data[14:0] : setup_r;
        lower_nxt = lower_r;
        upper_nxt = upper_r;
        if (req_kind == REQ_WRITE && req_ptr == PTR_LOWER) begin
            lower_nxt = req_data;
        end
        if (req_kind == REQ_WRITE && req_ptr == PTR_UPPER) begin
            upper_nxt = req_data;
        end
        result_nxt = done ? i_sample : result_r;
        ans_v_nxt = req_kind == REQ_READ || req_kind == REQ_ARA;
        ans_nxt = '0;
        if (req_kind == REQ_READ) begin
            case (req_ptr)
                PTR_RESULT: ans_nxt = result_r;
                PTR_SETUP: ans_nxt = {state_r == CONV_IDLE, setup_r};
                PTR_LOWER: ans_nxt = lower_r;
                PTR_UPPER: ans_nxt = upper_r;
                default: ans_nxt = '0;
            endcase
        end else if (req_kind == REQ_ARA && alert_act_r) begin
            // every read or alert-response request answers, but only an alerting device sets the hit bit and address; bitwise arbitration on the wire
            // lets the lowest address through
            ans_nxt[ARA_HIT_BIT] = 1'b1;
            ans_nxt[ADDR_LSB +: 7] = i_dev_addr;
        end
    end

    // limits start at the full code range so nothing alerts by default
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            setup_r <= SETUP_RST;
            lower_r <= LOWER_RST;
            upper_r <= UPPER_RST;
            result_r <= RESULT_RST;
            ans_v_r <= 1'b0;
            ans_r <= '0;
        end else begin
            setup_r <= setup_nxt;
            lower_r <= lower_nxt;
            upper_r <= upper_nxt;
            result_r <= result_nxt;
            ans_v_r <= ans_v_nxt;
            ans_r <= ans_nxt;
        end
    end

    //----------------------------------------
    // conversion timer
    //----------------------------------------
    logic [CONV_CNT_W-1:0] last_cnt;

    assign last_cnt = CONV_CNT_W'(RATE_CYC[rate_sel] - 1);
    assign done = state_r == CONV_RUN && cnt_r >= last_cnt;
    // a start request is honoured only from power-down
    assign start_single = wr_setup && req_data[START_BIT] && state_r == CONV_IDLE;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            CONV_IDLE: begin
                if (start_single || mode == MODE_CONT) begin
                    state_nxt = CONV_RUN;
                    cnt_nxt = '0;
                end
            end
            CONV_RUN: begin
                if (done) begin
                    cnt_nxt = '0;
                    if (mode != MODE_CONT) begin
                        state_nxt = CONV_IDLE;
                    end
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = CONV_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_r <= CONV_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    //----------------------------------------
    // comparator and alert pin
    //----------------------------------------
    logic comp_en, rdy_mode, above, below, out_lim, hit, clr_ev;
    logic [2:0] fault_r, fault_nxt, fault_inc;
    logic alert_act_nxt, alert_out_nxt, alert_oe_nxt;
    logic [RDY_CNT_W-1:0] rdy_cnt_r, rdy_cnt_nxt;
    logic [12:0] span_nxt;

    assign comp_en = HAS_COMPARATOR && que != QUE_OFF;
    assign rdy_mode = upper_r[15] && !lower_r[15];
    // limits are raw codes, so they track the gain only if software rewrites them
    assign above = $signed(i_sample) > $signed(upper_r);
    assign below = $signed(i_sample) < $signed(lower_r);
    assign out_lim = cmode == CMODE_WINDOW ? (above || below) : above;
    assign fault_inc = fault_r == FAULT_MAX ? FAULT_MAX : fault_r + 1'b1;
    assign hit = out_lim && fault_inc >= QUE_NEED[que];
    assign clr_ev = (req_kind == REQ_READ && req_ptr == PTR_RESULT) || req_kind == REQ_ARA;

    always_comb begin
        fault_nxt = fault_r;
        if (done) begin
            fault_nxt = out_lim ? fault_inc : 3'h0;
        end
        rdy_cnt_nxt = rdy_cnt_r;
        if (done && mode == MODE_CONT) begin
            rdy_cnt_nxt = RDY_CNT_W'(RDY_PULSE_CYC);
        end else if (rdy_cnt_r != '0) begin
            rdy_cnt_nxt = rdy_cnt_r - 1'b1;
        end
        alert_act_nxt = alert_act_r;
        if (!comp_en) begin
            alert_act_nxt = 1'b0;
        end else if (rdy_mode) begin
            // single-shot shows the status bit, continuous a pulse per result
            alert_act_nxt = mode == MODE_CONT ? rdy_cnt_r != '0 : state_r == CONV_IDLE;
        end else if (done && hit) begin
            alert_act_nxt = 1'b1;
        end else if (lat) begin
            if (clr_ev) begin
                alert_act_nxt = 1'b0;
            end
        end else if (done && (cmode == CMODE_WINDOW ? !out_lim : below)) begin
            alert_act_nxt = 1'b0;
        end
        alert_out_nxt = alert_act_nxt ^ ~pol;
        alert_oe_nxt = comp_en;
        span_nxt = HAS_COMPARATOR ? SPAN_MV[gain] : SPAN_FIXED;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            fault_r <= 3'h0;
            rdy_cnt_r <= '0;
            alert_act_r <= 1'b0;
            o_alert_out <= ~POL_RST;
            o_alert_oe <= 1'b0;
            o_span_mv <= SPAN_MV[GAIN_RST];
        end else begin
            fault_r <= fault_nxt;
            rdy_cnt_r <= rdy_cnt_nxt;
            alert_act_r <= alert_act_nxt;
            o_alert_out <= alert_out_nxt;
            o_alert_oe <= alert_oe_nxt;
            o_span_mv <= span_nxt;
        end
    end

    assign o_conv_busy = state_r == CONV_RUN;
    assign o_gain_range = gain;
    assign o_rate = rate_sel;

    //----------------------------------------
    // assertions
    //----------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_span_follow;
        wr_setup && HAS_COMPARATOR |-> ##2 o_span_mv == SPAN_MV[$past(req_data[GAIN_LSB +: 3], 2)];
    endproperty
    property p_cont_run;
        state_r == CONV_IDLE && mode == MODE_CONT |=> state_r == CONV_RUN && cnt_r == '0;
    endproperty
    property p_single_start;
        start_single |=> o_conv_busy ##1 o_conv_busy;
    endproperty
    property p_status_read;
        req_kind == REQ_READ && req_ptr == PTR_SETUP
            |=> ans_v_r && ans_r[START_BIT] == ($past(state_r) == CONV_IDLE);
    endproperty
    property p_comp_off;
        que == QUE_OFF && !wr_setup |=> !o_alert_oe [*2];
    endproperty
    property p_queue_one;
        comp_en && !rdy_mode && que == 2'h0 && done && out_lim |=> alert_act_r;
    endproperty
    property p_queue_two;
        comp_en && !rdy_mode && que == 2'h1 && done && out_lim && fault_r == 3'h0
            && !alert_act_r |=> !alert_act_r;
    endproperty
    property p_polarity;
        o_alert_oe |-> o_alert_out == (alert_act_r ^ ~$past(pol));
    endproperty
    property p_latch_hold;
        comp_en && !rdy_mode && lat && alert_act_r && !clr_ev |=> alert_act_r;
    endproperty
    property p_window_release;
        comp_en && !rdy_mode && !lat && cmode == CMODE_WINDOW && done && !out_lim
            |=> !alert_act_r;
    endproperty
    property p_rdy_single;
        comp_en && rdy_mode && mode != MODE_CONT |=> alert_act_r == ($past(state_r) == CONV_IDLE);
    endproperty
    property p_ara_answer;
        req_kind == REQ_ARA && alert_act_r
            |=> ans_r[ARA_HIT_BIT] && ans_r[ADDR_LSB +: 7] == $past(i_dev_addr);
    endproperty

    a_span_follow: assert property (p_span_follow) else $error("span wrong");
    a_cont_run: assert property (p_cont_run) else $error("no continuous start");
    a_single_start: assert property (p_single_start) else $error("no single start");
    a_status_read: assert property (p_status_read) else $error("status bit wrong");
    a_comp_off: assert property (p_comp_off) else $error("alert driven");
    a_queue_one: assert property (p_queue_one) else $error("queue one late");
    a_queue_two: assert property (p_queue_two) else $error("queue two early");
    a_polarity: assert property (p_polarity) else $error("alert polarity");
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost");
    a_window_release: assert property (p_window_release) else $error("no release");
    a_rdy_single: assert property (p_rdy_single) else $error("ready level");
    a_ara_answer: assert property (p_ara_answer) else $error("bad ara answer");

    c_single: cover property (start_single ##1 o_conv_busy);
    c_alert: cover property (!alert_act_r ##1 alert_act_r && !rdy_mode);
    c_rdy_pulse: cover property (rdy_cnt_r == RDY_CNT_W'(RDY_PULSE_CYC));
    c_ara: cover property (req_kind == REQ_ARA && alert_act_r);
endmodule // adc_config_threshold_comparator

// [test/link_engine_model.sv]
// serial engine model: issues register requests to the block on the link clock
`timescale 1ns/10ps
module link_engine_model (
    input wire logic i_lclk, // link clock
    input wire logic [15:0] i_rdata, // answer word
    input wire logic i_rvalid, // answer pulse
    output logic o_wr, // write pulse
    output logic o_rd, // read pulse
    output logic o_ara, // alert-response pulse
    output logic [1:0] o_ptr, // register pointer
    output logic [15:0] o_wdata // write word
);
    // idle bus at time zero
    initial begin
        {o_wr, o_rd, o_ara, o_ptr, o_wdata} = '0;
    end
    // kind is {wr, rd, ara}; qualifiers scrambled after release, spacing kept
    task automatic req(input logic [2:0] kind, input logic [1:0] ptr, input logic [15:0] d,
                       output logic [15:0] ans);
        int n;
        ans = 16'hxxxx;
        @(negedge i_lclk);
        {o_wr, o_rd, o_ara} = kind;
        o_ptr = ptr;
        o_wdata = d;
        @(negedge i_lclk);
        {o_wr, o_rd, o_ara} = 3'h0;
        o_ptr = ~ptr;
        o_wdata = ~d;
        for (n = 0; n < 14; n++) begin
            @(negedge i_lclk);
            if (i_rvalid === 1'b1) begin
                ans = i_rdata;
            end
        end
        repeat (8) @(negedge i_lclk);
    endtask
endmodule // link_engine_model

// [test/adc_config_threshold_comparator_tb_top.sv]
// bench: register access, conversions and alert pin of the converter setup block
`timescale 1ns/10ps
module adc_config_threshold_comparator_tb_top;
    import adc_cfg_pkg::*;
    localparam int unsigned CYC [RATE_NUM] = '{400, 360, 320, 280, 240, 200, 160, 120};
    logic i_mclk = 1'b0;
    logic i_lclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] i_sample = 16'h0000;
    logic i_lwr, i_lrd, i_lara, o_lrvalid, o_alert_out, o_alert_oe, o_conv_busy;
    logic [1:0] i_lptr;
    logic [15:0] i_lwdata, o_lrdata, ans;
    logic [2:0] o_gain_range, o_rate;
    logic [12:0] o_span_mv;
    logic [12:0] fx_span;
    logic fx_oe;
    logic [12:0] span_exp [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400,
                                  13'h0200, 13'h0100, 13'h0100, 13'h0100};
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int k;
    int n;
    // core and link clocks, unrelated rates
    always #12.5 i_mclk = ~i_mclk;
    always #24 i_lclk = ~i_lclk;
    adc_config_threshold_comparator #(.HAS_COMPARATOR(1'b1), .RATE_CYC(CYC)) i_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sample(i_sample), .i_dev_addr(7'h2a),
        .i_lclk(i_lclk), .i_lwr(i_lwr), .i_lrd(i_lrd), .i_lara(i_lara), .i_lptr(i_lptr),
        .i_lwdata(i_lwdata), .o_lrdata(o_lrdata), .o_lrvalid(o_lrvalid),
        .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe), .o_conv_busy(o_conv_busy),
        .o_gain_range(o_gain_range), .o_rate(o_rate), .o_span_mv(o_span_mv));
    // fixed-span variant on the same link, only its span and pin enable are watched
    adc_config_threshold_comparator #(.HAS_COMPARATOR(1'b0), .RATE_CYC(CYC)) i_dut_fixed (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sample(i_sample), .i_dev_addr(7'h2b),
        .i_lclk(i_lclk), .i_lwr(i_lwr), .i_lrd(i_lrd), .i_lara(i_lara), .i_lptr(i_lptr),
        .i_lwdata(i_lwdata), .o_lrdata(), .o_lrvalid(), .o_alert_out(), .o_alert_oe(fx_oe),
        .o_conv_busy(), .o_gain_range(), .o_rate(), .o_span_mv(fx_span));
    link_engine_model i_link (
        .i_lclk(i_lclk), .i_rdata(o_lrdata), .i_rvalid(o_lrvalid), .o_wr(i_lwr),
        .o_rd(i_lrd), .o_ara(i_lara), .o_ptr(i_lptr), .o_wdata(i_lwdata));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // setup word with rate code 4
    function automatic logic [15:0] cfg(input logic st, input logic [2:0] g, input logic md,
        input logic cm, input logic pl, input logic lt, input logic [1:0] q);
        return {st, 3'h0, g, md, 3'h4, cm, pl, lt, q};
    endfunction
    // one single-shot conversion of a sample, then the pin level after it ends
    task automatic conv(input logic [15:0] s, input logic [15:0] setup, input logic pin);
        int n;
        @(negedge i_mclk);
        for (n = 0; n < 1000 && o_conv_busy !== 1'b0; n++) @(negedge i_mclk);
        i_sample = s;
        i_link.req(3'h4, PTR_SETUP, setup, ans);
        for (n = 0; n < 1000 && o_conv_busy !== 1'b0; n++) @(negedge i_mclk);
        check({15'h0, o_conv_busy}, 16'h0);
        repeat (3) @(negedge i_mclk);
        check({15'h0, o_alert_out}, {15'h0, pin});
    endtask
    // hang guard
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        repeat (6) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (4) @(posedge i_lclk);
        i_link.req(3'h2, PTR_SETUP, 16'h0, ans);
        check(ans, 16'h8583);
        i_link.req(3'h2, PTR_LOWER, 16'h0, ans);
        check(ans, 16'h8000);
        i_link.req(3'h2, PTR_UPPER, 16'h0, ans);
        check(ans, 16'h7fff);
        check({15'h0, o_alert_oe}, 16'h0);
        $display("test reset done");
        for (k = 0; k < 8; k++) begin
            i_link.req(3'h4, PTR_SETUP, {4'h0, k[2:0], 1'b1, k[2:0], 5'h03}, ans);
            check({3'h0, o_span_mv}, {3'h0, span_exp[k]});
            check({10'h0, o_gain_range, o_rate}, {10'h0, k[2:0], k[2:0]});
            check({3'h0, fx_span}, 16'h0800);
        end
        $display("test gain and rate done");
        i_link.req(3'h4, PTR_LOWER, 16'h0010, ans);
        i_link.req(3'h4, PTR_UPPER, 16'h0100, ans);
        i_link.req(3'h4, PTR_SETUP, cfg(1, 2, 1, 0, 0, 0, 0), ans);
        i_link.req(3'h2, PTR_SETUP, 16'h0, ans);
        check({15'h0, ans[15]}, 16'h0);
        conv(16'h0200, cfg(1, 2, 1, 0, 0, 0, 0), 1'b0);
        check({15'h0, o_alert_oe}, 16'h1);
        check({15'h0, fx_oe}, 16'h0);
        conv(16'h0050, cfg(1, 2, 1, 0, 0, 0, 0), 1'b0);
        conv(16'hfff0, cfg(1, 2, 1, 0, 0, 0, 0), 1'b1);
        for (k = 0; k < 3; k++) begin
            conv(16'hfff0, cfg(1, 2, 1, 0, 1, 0, k[1:0]), 1'b0);
            repeat ((1 << k) - 1) conv(16'h0200, cfg(1, 2, 1, 0, 1, 0, k[1:0]), 1'b0);
            conv(16'h0200, cfg(1, 2, 1, 0, 1, 0, k[1:0]), 1'b1);
        end
        $display("test comparator done");
        conv(16'h0200, cfg(1, 2, 1, 1, 1, 1, 0), 1'b1);
        conv(16'h0050, cfg(1, 2, 1, 1, 1, 1, 0), 1'b1);
        i_link.req(3'h1, PTR_RESULT, 16'h0, ans);
        check(ans, {1'b1, 7'h0, 7'h2a, 1'b0});
        check({15'h0, o_alert_out}, 16'h0);
        i_link.req(3'h1, PTR_RESULT, 16'h0, ans);
        check(ans, 16'h0000);
        conv(16'hfff0, cfg(1, 2, 1, 1, 1, 1, 0), 1'b1);
        i_link.req(3'h2, PTR_RESULT, 16'h0, ans);
        check(ans, 16'hfff0);
        check({15'h0, o_alert_out}, 16'h0);
        conv(16'h0200, cfg(1, 2, 1, 1, 1, 0, 0), 1'b1);
        conv(16'h0050, cfg(1, 2, 1, 1, 1, 0, 0), 1'b0);
        $display("test latch done");
        i_link.req(3'h4, PTR_UPPER, 16'h8000, ans);
        i_link.req(3'h4, PTR_LOWER, 16'h0000, ans);
        conv(16'h8000, cfg(1, 2, 1, 0, 1, 0, 0), 1'b1);
        $display("test ready done");
        // continuous mode at the slowest rate: one ready pulse per result
        i_link.req(3'h4, PTR_SETUP, 16'h0408, ans);
        for (n = 0; n < 1000 && o_alert_out !== 1'b1; n++) @(negedge i_mclk);
        check({15'h0, o_conv_busy}, 16'h1);
        for (n = 0; n < 1000 && o_alert_out === 1'b1; n++) @(negedge i_mclk);
        check(16'(n), 16'(RDY_PULSE_CYC));
        $display("test continuous done");
        stop_test();
    end
endmodule // adc_config_threshold_comparator_tb_top
